// >>> rtl/rbs_boot_sequencer.v
`timescale 1ns/100ps
`include "rbs_boot_map.vh"
module rbs_boot_sequencer
#(
  parameter SETTLE_CYC        = `RBS_SETTLE_CYC,
  parameter PROBE_TIMEOUT_CYC = `RBS_PROBE_TIMEOUT_CYC
)
(
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        clk_sel_strap_i,
  input  wire        probe_done_i,
  input  wire        probe_sig_ok_i,
  input  wire        probe_err_i,
  input  wire        cfg_present_i,
  input  wire        cfg_done_i,
  input  wire        load_done_i,
  input  wire        load_err_i,
  input  wire [23:0] entry_addr_i,
  output wire [23:0] fetch_addr_o,
  output wire        fetch_req_o,
  output wire        memory_map_select_o,
  output wire        pll_bypass_o,
  output wire        pll_power_up_o,
  output wire [11:0] pll_multiplier_field_o,
  output wire [1:0]  pll_secondary_field_o,
  output wire        pll_input_div_en_o,
  output wire        pll_div8_en_o,
  output wire [1:0]  pll_output_divider_field_o,
  output wire        clock_output_pin_slow_slew_o,
  output wire        clock_output_pin_en_o,
  output wire        periph_idle_o,
  output wire        memory_port_idle_o,
  output wire        hardware_accelerator_idle_o,
  output wire        cpu_idle_o,
  output wire        bandgap_trim_load_o,
  output wire [4:0]  periph_clk_en_o,
  output wire [2:0]  external_bus_selection_mode_o,
  output wire        probe_req_o,
  output wire [2:0]  probe_src_o,
  output wire        spi_addr24_o,
  output wire [9:0]  bus_rate_khz_o,
  output wire [6:0]  i2c_target_addr_o,
  output wire [16:0] uart_baud_o,
  output wire        uart_odd_parity_o,
  output wire        uart_flow_ctl_o,
  output wire        usb_ldo_en_o,
  output wire [3:0]  usb_out_ep_o,
  output wire        cfg_req_o,
  output wire        load_req_o,
  output wire        scratch_reserved_o,
  output wire [4:0]  scratch_block_o,
  output wire        jump_o,
  output wire [23:0] jump_addr_o,
  output wire        boot_busy_o
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [14:0] S_VEC    = 15'h0001;
  localparam [14:0] S_SLEW   = 15'h0002;
  localparam [14:0] S_IDLE   = 15'h0004;
  localparam [14:0] S_CLK    = 15'h0008;
  localparam [14:0] S_TRIM   = 15'h0010;
  localparam [14:0] S_CKOFF  = 15'h0020;
  localparam [14:0] S_EXTERNAL_BUS_SELECTION   = 15'h0040;
  localparam [14:0] S_PROBE  = 15'h0080;
  localparam [14:0] S_WAIT   = 15'h0100;
  localparam [14:0] S_CFG    = 15'h0200;
  localparam [14:0] S_LOAD   = 15'h0400;
  localparam [14:0] S_SETTLE = 15'h0800;
  localparam [14:0] S_JUMP   = 15'h1000;
  localparam [14:0] S_DONE   = 15'h2000;
  localparam [14:0] S_RETUNE = 15'h4000;

  localparam [31:0]           TMO_FULL = PROBE_TIMEOUT_CYC - 1;
  localparam [`RBS_TMO_W-1:0] TMO_LAST = TMO_FULL[`RBS_TMO_W-1:0];

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [14:0]            state_q;
  reg  [14:0]            state_d;
  reg  [2:0]             src_q;
  reg  [2:0]             src_d;
  reg  [`RBS_TMO_W-1:0]  tmo_q;
  reg                    strap_q;
  reg  [23:0]            fetch_addr_q;
  reg                    fetch_req_q;
  reg                    pll_bypass_q;
  reg                    pll_power_up_q;
  reg  [11:0]            pll_mult_q;
  reg                    pll_div8_q;
  reg                    ck_slow_q;
  reg                    ck_en_q;
  reg                    idle_armed_q;
  reg                    periph_idle_q;
  reg                    bg_trim_q;
  reg  [4:0]             pclk_q;
  reg  [2:0]             external_bus_selection_q;
  reg                    probe_req_q;
  reg  [2:0]             probe_src_q;
  reg                    spi_addr24_q;
  reg  [9:0]             rate_q;
  reg                    serial_cfg_q;
  reg                    usb_ldo_q;
  reg                    cfg_req_q;
  reg                    load_req_q;
  reg                    scratch_q;
  reg                    jump_q;
  reg  [23:0]            jump_addr_q;
  reg  [23:0]            entry_q;
  reg                    busy_q;
  wire                   strap_sync;
  wire                   settle_done;
  wire                   probe_ok;
  wire                   probe_fail;
  wire                   query_active;
  wire                   timer_start;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [2:0] rbs_next_src;
    input [2:0] s;
    begin
      case (s)
        `RBS_SRC_SPI16: rbs_next_src = `RBS_SRC_SPI24;
        `RBS_SRC_SPI24: rbs_next_src = `RBS_SRC_I2C;
        `RBS_SRC_I2C:   rbs_next_src = `RBS_SRC_CARD;
        `RBS_SRC_UART:  rbs_next_src = `RBS_SRC_USB;
        default:        rbs_next_src = `RBS_SRC_UART;
      endcase
    end
  endfunction

  function [4:0] rbs_clk_bit;
    input [2:0] s;
    begin
      rbs_clk_bit = 5'h00;
      case (s)
        `RBS_SRC_SPI16: rbs_clk_bit[`RBS_CLK_SPI] = 1'b1;
        `RBS_SRC_SPI24: rbs_clk_bit[`RBS_CLK_SPI] = 1'b1;
        `RBS_SRC_I2C:   rbs_clk_bit[`RBS_CLK_I2C] = 1'b1;
        `RBS_SRC_CARD:  rbs_clk_bit[`RBS_CLK_CARD] = 1'b1;
        `RBS_SRC_UART:  rbs_clk_bit[`RBS_CLK_UART] = 1'b1;
        default:        rbs_clk_bit[`RBS_CLK_USB] = 1'b1;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Strap synchroniser and settling timer
  // ------------------------------------------------------------
  rbs_sync2 u_strap_sync
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (clk_sel_strap_i),
    .q_o       (strap_sync)
  );

  assign timer_start = (state_q == S_CLK) || (state_q == S_RETUNE);

  rbs_settle_timer
  #(
    .CYCLES (SETTLE_CYC),
    .WIDTH  (`RBS_SETTLE_W)
  )
  u_settle
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (timer_start),
    .done_o    (settle_done)
  );

  // ------------------------------------------------------------
  // Probe outcome
  // ------------------------------------------------------------
  // A silent source must not hang the chain, hence the timeout
  assign probe_ok   = probe_done_i && probe_sig_ok_i && !probe_err_i;
  assign probe_fail = (probe_done_i && !probe_ok) || (tmo_q == TMO_LAST);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    src_d   = src_q;
    case (state_q)
      S_VEC:    state_d = S_SLEW;
      S_SLEW:   state_d = S_IDLE;
      S_IDLE:   state_d = S_CLK;
      S_CLK:    state_d = S_TRIM;
      S_TRIM:   state_d = S_CKOFF;
      S_CKOFF:  state_d = S_EXTERNAL_BUS_SELECTION;
      S_EXTERNAL_BUS_SELECTION:   state_d = S_PROBE;
      S_PROBE:  state_d = S_WAIT;
      S_WAIT:
      begin
        if (probe_ok)
        begin
          state_d = cfg_present_i ? S_CFG : S_LOAD;
        end
        else if (probe_fail)
        begin
          src_d   = rbs_next_src(src_q);
          state_d = (src_q == `RBS_SRC_CARD) ? S_RETUNE : S_PROBE;
        end
      end
      S_CFG:
      begin
        if (cfg_done_i)
        begin
          state_d = S_LOAD;
        end
      end
      S_LOAD:
      begin
        if (load_done_i)
        begin
          state_d = S_SETTLE;
        end
        else if (load_err_i)
        begin
          src_d   = rbs_next_src(src_q);
          state_d = (src_q == `RBS_SRC_CARD) ? S_RETUNE : S_PROBE;
        end
      end
      S_SETTLE:
      begin
        if (settle_done)
        begin
          state_d = S_JUMP;
        end
      end
      S_JUMP:   state_d = S_DONE;
      S_DONE:   state_d = S_DONE;
      S_RETUNE: state_d = S_PROBE;
      default:  state_d = S_VEC;
    endcase
  end

  // The peripheral under query is the only one clocked; the single periph_idle_o wakes all peripherals while it is queried
  assign query_active = (state_d == S_PROBE) || (state_d == S_WAIT) ||
                        (state_d == S_CFG) || (state_d == S_LOAD);

  // ------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q        <= S_VEC;
      src_q          <= `RBS_SRC_SPI16;
      tmo_q          <= {`RBS_TMO_W{1'b0}};
      strap_q        <= 1'b0;
      fetch_addr_q   <= `RBS_RESET_VECTOR;
      fetch_req_q    <= 1'b0;
      pll_bypass_q   <= 1'b1;
      pll_power_up_q <= 1'b0;
      pll_mult_q     <= 12'h000;
      pll_div8_q     <= 1'b0;
      ck_slow_q      <= 1'b0;
      ck_en_q        <= 1'b1;
      idle_armed_q   <= 1'b0;
      periph_idle_q  <= 1'b0;
      bg_trim_q      <= 1'b0;
      pclk_q         <= 5'h00;
      external_bus_selection_q         <= 3'h0;
      probe_req_q    <= 1'b0;
      probe_src_q    <= `RBS_SRC_SPI16;
      spi_addr24_q   <= 1'b0;
      rate_q         <= 10'h000;
      serial_cfg_q   <= 1'b0;
      usb_ldo_q      <= 1'b0;
      cfg_req_q      <= 1'b0;
      load_req_q     <= 1'b0;
      scratch_q      <= 1'b1;
      jump_q         <= 1'b0;
      jump_addr_q    <= 24'h000000;
      entry_q        <= 24'h000000;
      busy_q         <= 1'b1;
    end
    else
    begin
      state_q     <= state_d;
      src_q       <= src_d;
      fetch_req_q <= (state_q == S_VEC);
      bg_trim_q   <= (state_q == S_TRIM);
      probe_req_q <= (state_q == S_PROBE);
      cfg_req_q   <= (state_d == S_CFG) && (state_q != S_CFG);
      load_req_q  <= (state_d == S_LOAD) && (state_q != S_LOAD);
      jump_q      <= (state_q == S_JUMP);
      tmo_q       <= (state_q == S_WAIT) ? tmo_q + {{(`RBS_TMO_W-1){1'b0}}, 1'b1} : {`RBS_TMO_W{1'b0}};
      pclk_q        <= query_active ? rbs_clk_bit(src_d) : 5'h00;
      periph_idle_q <= idle_armed_q && !query_active;
      probe_src_q   <= src_d;
      spi_addr24_q  <= (src_d == `RBS_SRC_SPI24);
      if (src_d == `RBS_SRC_I2C)
      begin
        rate_q <= `RBS_I2C_RATE_KHZ;
      end
      else
      begin
        rate_q <= `RBS_SPI_RATE_KHZ;
      end
      if (load_done_i && state_q == S_LOAD)
      begin
        entry_q <= entry_addr_i;
      end
      case (state_q)
        S_SLEW:
        begin
          ck_slow_q <= 1'b1;
        end
        S_IDLE:
        begin
          idle_armed_q <= 1'b1;
          strap_q      <= strap_sync;
        end
        S_CLK:
        begin
          if (!strap_q)
          begin
            pll_power_up_q <= 1'b1;
            pll_bypass_q   <= 1'b0;
            pll_mult_q     <= `RBS_PLL_MULT_BOOT_LO;
            pll_div8_q     <= 1'b1;
          end
        end
        S_CKOFF:
        begin
          ck_en_q <= 1'b0;
        end
        S_EXTERNAL_BUS_SELECTION:
        begin
          external_bus_selection_q <= `RBS_EXTERNAL_BUS_SELECTION_MODE_FIRST;
        end
        S_PROBE:
        begin
          if (external_bus_selection_q == `RBS_EXTERNAL_BUS_SELECTION_MODE_FIRST)
          begin
            external_bus_selection_q <= `RBS_EXTERNAL_BUS_SELECTION_MODE_SECOND;
          end
        end
        S_RETUNE:
        begin
          pll_power_up_q <= 1'b1;
          pll_bypass_q   <= 1'b0;
          pll_mult_q     <= strap_q ? `RBS_PLL_MULT_RETUNE_HI : `RBS_PLL_MULT_RETUNE_LO;
          serial_cfg_q   <= 1'b1;
          usb_ldo_q      <= 1'b1;
        end
        S_JUMP:
        begin
          jump_addr_q <= entry_q;
          scratch_q   <= 1'b0;
          busy_q      <= 1'b0;
        end
        default:
        begin
          busy_q <= busy_q;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Fixed fields are constants; only live state needs flops
  assign fetch_addr_o                  = fetch_addr_q;
  assign fetch_req_o                   = fetch_req_q;
  assign memory_map_select_o           = `RBS_MAP_SELECT_RESET;
  assign pll_bypass_o                  = pll_bypass_q;
  assign pll_power_up_o                = pll_power_up_q;
  assign pll_multiplier_field_o        = pll_mult_q;
  assign pll_secondary_field_o         = `RBS_PLL_SEC_FIELD;
  assign pll_input_div_en_o            = 1'b0;
  assign pll_div8_en_o                 = pll_div8_q;
  assign pll_output_divider_field_o    = `RBS_PLL_OUT_DIV_FIELD;
  assign clock_output_pin_slow_slew_o  = ck_slow_q;
  assign clock_output_pin_en_o         = ck_en_q;
  assign periph_idle_o                 = periph_idle_q;
  assign memory_port_idle_o            = idle_armed_q;
  assign hardware_accelerator_idle_o   = idle_armed_q;
  assign cpu_idle_o                    = 1'b0;
  assign bandgap_trim_load_o           = bg_trim_q;
  assign periph_clk_en_o               = pclk_q;
  assign external_bus_selection_mode_o = external_bus_selection_q;
  assign probe_req_o                   = probe_req_q;
  assign probe_src_o                   = probe_src_q;
  assign spi_addr24_o                  = spi_addr24_q;
  assign bus_rate_khz_o                = rate_q;
  assign i2c_target_addr_o             = `RBS_I2C_TARGET;
  assign uart_baud_o                   = serial_cfg_q ? `RBS_UART_BAUD : 17'h00000;
  assign uart_odd_parity_o             = serial_cfg_q;
  assign uart_flow_ctl_o               = serial_cfg_q;
  assign usb_ldo_en_o                  = usb_ldo_q;
  assign usb_out_ep_o                  = usb_ldo_q ? `RBS_USB_OUT_EP : 4'h0;
  assign cfg_req_o                     = cfg_req_q;
  assign load_req_o                    = load_req_q;
  assign scratch_reserved_o            = scratch_q;
  assign scratch_block_o               = `RBS_SCRATCH_BLOCK;
  assign jump_o                        = jump_q;
  assign jump_addr_o                   = jump_addr_q;
  assign boot_busy_o                   = busy_q;

endmodule

// >>> rtl/rbs_settle_timer.v
`timescale 1ns/100ps
module rbs_settle_timer
#(
  parameter CYCLES = 2000000,
  parameter WIDTH  = 21
)
(
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire start_i,
  output wire done_o
);

  localparam [31:0]      LOAD_FULL = CYCLES - 1;
  localparam [WIDTH-1:0] LOAD_VAL  = LOAD_FULL[WIDTH-1:0];

  reg [WIDTH-1:0] cnt_q;
  reg             busy_q;
  reg             done_q;

  // Restart discards any interval in progress
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_q  <= LOAD_VAL;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (busy_q && cnt_q != {WIDTH{1'b0}})
    begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    else if (busy_q)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  assign done_o = done_q;

endmodule

// >>> rtl/rbs_sync2.v
`timescale 1ns/100ps
module rbs_sync2
(
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// >>> shared/rbs_boot_map.vh
`ifndef RBS_BOOT_MAP_VH
`define RBS_BOOT_MAP_VH

// ------------------------------------------------------------
// Reset vector and memory map
// ------------------------------------------------------------
`define RBS_RESET_VECTOR        24'hffff00
`define RBS_MAP_SELECT_RESET    1'b0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RBS_SYS_CLK_KHZ         10000
`define RBS_SETTLE_MS           200
`define RBS_SETTLE_CYC          (`RBS_SETTLE_MS * `RBS_SYS_CLK_KHZ)
`define RBS_SETTLE_W            21
`define RBS_PROBE_TIMEOUT_CYC   4096
`define RBS_TMO_W               13

// ------------------------------------------------------------
// Clock generator settings
// ------------------------------------------------------------
`define RBS_PLL_MULT_BOOT_LO    12'h2ed
`define RBS_PLL_MULT_RETUNE_LO  12'h8c9
`define RBS_PLL_MULT_RETUNE_HI  12'h005
`define RBS_PLL_SEC_FIELD       2'h0
`define RBS_PLL_OUT_DIV_FIELD   2'h0

// ------------------------------------------------------------
// Boot sources and probe settings
// ------------------------------------------------------------
`define RBS_SRC_SPI16           3'h0
`define RBS_SRC_SPI24           3'h1
`define RBS_SRC_I2C             3'h2
`define RBS_SRC_CARD            3'h3
`define RBS_SRC_UART            3'h4
`define RBS_SRC_USB             3'h5
`define RBS_CLK_SPI             0
`define RBS_CLK_I2C             1
`define RBS_CLK_CARD            2
`define RBS_CLK_UART            3
`define RBS_CLK_USB             4
`define RBS_EXTERNAL_BUS_SELECTION_MODE_FIRST     3'h5
`define RBS_EXTERNAL_BUS_SELECTION_MODE_SECOND    3'h6
`define RBS_SPI_RATE_KHZ        10'h1f4
`define RBS_I2C_RATE_KHZ        10'h190
`define RBS_I2C_TARGET          7'h50
`define RBS_UART_BAUD           17'h0e100
`define RBS_USB_OUT_EP          4'h1
`define RBS_SCRATCH_BLOCK       5'h1f

`endif

// >>> tb/rbs_boot_partner.sv
`timescale 1ns/100ps
module rbs_boot_partner
(
  input  wire        sys_clk_i,
  input  wire        probe_req_i,
  input  wire [2:0]  probe_src_i,
  input  wire        cfg_req_i,
  input  wire        load_req_i,
  input  wire [2:0]  good_src_i,
  input  wire [1:0]  fail_mode_i,
  input  wire [3:0]  delay_i,
  input  wire        cfg_i,
  input  wire        load_bad_i,
  input  wire [23:0] entry_i,
  output reg         probe_done_o,
  output reg         probe_sig_ok_o,
  output reg         probe_err_o,
  output reg         cfg_present_o,
  output reg         cfg_done_o,
  output reg         load_done_o,
  output reg         load_err_o,
  output reg  [23:0] entry_addr_o
);
  reg [2:0] kind;
  reg       ok;
  initial
  begin
    {probe_done_o, probe_sig_ok_o, probe_err_o, cfg_present_o} = 4'h0;
    {cfg_done_o, load_done_o, load_err_o, entry_addr_o} = 27'h0;
    forever
    begin
      @(posedge sys_clk_i);
      kind = {load_req_i, cfg_req_i, probe_req_i};
      ok = probe_src_i == good_src_i;
      if (kind != 3'h0)
      begin
        repeat (delay_i) @(posedge sys_clk_i);
        #1;
        // Silent mode lets the probe time out
        if (kind == 3'h1)
        begin
          probe_done_o = ok || fail_mode_i != 2'h2;
          probe_sig_ok_o = ok;
          probe_err_o = !ok && fail_mode_i == 2'h1;
          cfg_present_o = cfg_i;
        end
        else if (kind == 3'h2)
          cfg_done_o = 1'b1;
        else
        begin
          load_done_o = !load_bad_i;
          load_err_o = load_bad_i;
          entry_addr_o = entry_i;
        end
        @(posedge sys_clk_i);
        #1;
        {probe_done_o, probe_err_o, cfg_done_o, load_done_o, load_err_o} = 5'h00;
        probe_sig_ok_o = ~probe_sig_ok_o;
        entry_addr_o = ~entry_addr_o;
      end
    end
  end
endmodule

// >>> tb/rbs_boot_props.sv
`timescale 1ns/100ps
module rbs_boot_props
#(
  parameter SETTLE_CYC = 50
)
(
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        clk_sel_strap_i,
  input wire [23:0] fetch_addr_o,
  input wire        fetch_req_o,
  input wire        memory_map_select_o,
  input wire        pll_bypass_o,
  input wire        pll_power_up_o,
  input wire [11:0] pll_multiplier_field_o,
  input wire        pll_div8_en_o,
  input wire        clock_output_pin_en_o,
  input wire        clock_output_pin_slow_slew_o,
  input wire        memory_port_idle_o,
  input wire        bandgap_trim_load_o,
  input wire [4:0]  periph_clk_en_o,
  input wire [2:0]  external_bus_selection_mode_o,
  input wire        probe_req_o,
  input wire [2:0]  probe_src_o,
  input wire        spi_addr24_o,
  input wire [9:0]  bus_rate_khz_o,
  input wire [16:0] uart_baud_o,
  input wire        usb_ldo_en_o,
  input wire        jump_o,
  input wire [23:0] jump_addr_o,
  input wire        scratch_reserved_o
);
  // ----------------------------------------
  // Cycle counters since release and restart
  // ----------------------------------------
  reg [31:0] rel_q;
  reg [31:0] start_q;
  wire [2:0] ebs = external_bus_selection_mode_o;
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      rel_q   <= 0;
      start_q <= 0;
    end
    else
    begin
      rel_q   <= rel_q + 1;
      start_q <= $rose(usb_ldo_en_o) ? 0 : start_q + 1;
    end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  boot_vector_a: assert property (fetch_req_o |-> rel_q == 1 && fetch_addr_o == 24'hffff00
    && !memory_map_select_o && pll_bypass_o) else $error("reset fetch wrong");
  idle_trim_a: assert property (bandgap_trim_load_o |-> clock_output_pin_en_o
    && clock_output_pin_slow_slew_o && memory_port_idle_o ##1 !clock_output_pin_en_o) else $error("trim order");
  pll_boot_a: assert property (probe_req_o && probe_src_o < 3'h4 |-> (clk_sel_strap_i ? pll_bypass_o
    : pll_multiplier_field_o == 12'h2ed && pll_div8_en_o && pll_power_up_o)) else $error("boot clock");
  spi_first_a: assert property (probe_req_o && probe_src_o == 3'h0 |-> ebs == 3'h6
    && bus_rate_khz_o == 10'h1f4 && periph_clk_en_o == 5'h01) else $error("spi probe setup");
  bus_mode_a: assert property ($changed(ebs) |-> ($past(ebs) == 3'h0 && ebs == 3'h5)
    || ($past(ebs) == 3'h5 && ebs == 3'h6)) else $error("bus mode order");
  spi_wide_a: assert property (probe_req_o && probe_src_o == 3'h1 |-> spi_addr24_o
    && bus_rate_khz_o == 10'h1f4) else $error("spi retry setup");
  i2c_probe_a: assert property (probe_req_o && probe_src_o == 3'h2 |-> bus_rate_khz_o == 10'h190
    && periph_clk_en_o == 5'h02) else $error("i2c probe setup");
  src_order_a: assert property ($changed(probe_src_o) |-> probe_src_o == $past(probe_src_o) + 3'h1
    || probe_src_o == 3'h4) else $error("source order");
  serial_cfg_a: assert property (probe_req_o && probe_src_o > 3'h3 |-> uart_baud_o == 17'h0e100
    && usb_ldo_en_o && !pll_bypass_o && pll_multiplier_field_o == (clk_sel_strap_i ? 12'h005 : 12'h8c9))
    else $error("serial setup");
  handoff_a: assert property (jump_o |-> periph_clk_en_o == 5'h00 && start_q >= SETTLE_CYC
    ##1 !scratch_reserved_o && $stable(jump_addr_o)) else $error("handoff state");
  cover property (jump_o);
  cover property (probe_req_o && probe_src_o == 3'h1);
  cover property (probe_req_o && probe_src_o == 3'h5);
endmodule
bind rbs_boot_sequencer rbs_boot_props #(.SETTLE_CYC(SETTLE_CYC)) i_props (.*);

// >>> tb/reset_boot_image_sequencer_test.sv
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    samples_checked = samples_checked + 1; \
    if ((a) !== (b)) \
    begin \
      failures = failures + 1; \
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, (a), (b)); \
    end \
  end
module reset_boot_image_sequencer_test;
  reg         sys_clk_i, rst_i, clk_sel_strap_i, cfg, load_bad;
  reg  [2:0]  good_src;
  reg  [1:0]  fail_mode;
  reg  [3:0]  delay;
  reg  [23:0] entry;
  reg  [15:0] rnd;
  reg  [2:0]  seq [0:63];
  integer     failures, samples_checked, cyc, nreq, k;
  wire        probe_done_i, probe_sig_ok_i, probe_err_i, cfg_present_i, cfg_done_i, load_done_i, load_err_i;
  wire [23:0] entry_addr_i, fetch_addr_o, jump_addr_o;
  wire [11:0] pll_multiplier_field_o;
  wire [1:0]  pll_secondary_field_o, pll_output_divider_field_o;
  wire [4:0]  periph_clk_en_o, scratch_block_o;
  wire [2:0]  external_bus_selection_mode_o, probe_src_o;
  wire [9:0]  bus_rate_khz_o;
  wire [6:0]  i2c_target_addr_o;
  wire [16:0] uart_baud_o;
  wire [3:0]  usb_out_ep_o;
  wire        fetch_req_o, memory_map_select_o, pll_bypass_o, pll_power_up_o, pll_input_div_en_o, pll_div8_en_o;
  wire        clock_output_pin_slow_slew_o, clock_output_pin_en_o, periph_idle_o, memory_port_idle_o;
  wire        hardware_accelerator_idle_o, cpu_idle_o, bandgap_trim_load_o, probe_req_o, spi_addr24_o;
  wire        uart_odd_parity_o, uart_flow_ctl_o, usb_ldo_en_o, cfg_req_o, load_req_o;
  wire        scratch_reserved_o, jump_o, boot_busy_o;
  rbs_boot_sequencer #(.SETTLE_CYC(50), .PROBE_TIMEOUT_CYC(20)) i_dut (.*);
  rbs_boot_partner i_far (.sys_clk_i, .probe_req_i(probe_req_o), .probe_src_i(probe_src_o),
    .cfg_req_i(cfg_req_o), .load_req_i(load_req_o), .good_src_i(good_src), .fail_mode_i(fail_mode),
    .delay_i(delay), .cfg_i(cfg), .load_bad_i(load_bad), .entry_i(entry), .probe_done_o(probe_done_i),
    .probe_sig_ok_o(probe_sig_ok_i), .probe_err_o(probe_err_i), .cfg_present_o(cfg_present_i),
    .cfg_done_o(cfg_done_i), .load_done_o(load_done_i), .load_err_o(load_err_i), .entry_addr_o(entry_addr_i));
  // ----------------------------------------
  // Clock, probe log and helpers
  // ----------------------------------------
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc = cyc + 1;
    if (probe_req_o === 1'b1 && nreq < 64)
    begin
      seq[nreq] = probe_src_o;
      nreq = nreq + 1;
    end
  end
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [2:0] exp_src(input integer n);
    exp_src = n < 4 ? n[2:0] : 3'h4 + n[0];
  endfunction
  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Good source 7 means none answers until the serial loop has turned a few times
  task boot(input strap, input [2:0] good, input [1:0] fmode, input bad_first);
    integer i;
    begin
      rnd = lfsr(rnd);
      #1 rst_i = 1'b1;
      clk_sel_strap_i = strap;
      {good_src, fail_mode, load_bad} = {good, fmode, bad_first};
      {delay, cfg} = rnd[4:0];
      entry = {rnd, rnd[7:0]};
      repeat (8) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      {cyc, nreq} = 0;
      for (i = 0; i < 3000 && jump_o !== 1'b1; i = i + 1)
      begin
        @(posedge sys_clk_i);
        // Off the partner's own drive instant
        #2;
        if (load_err_i === 1'b1)
          {load_bad, good_src} = {1'b0, good_src + 3'h1};
        if (good_src == 3'h7 && nreq > 8)
          good_src = 3'h5;
      end
      `CHK(jump_o, 1'b1);
      if (jump_o !== 1'b1)
        complete_run;
      else
      begin
        `CHK(cyc >= 50, 1'b1);
        @(posedge sys_clk_i);
        #1;
        `CHK(jump_addr_o, entry);
        `CHK({periph_clk_en_o, periph_idle_o, memory_port_idle_o, hardware_accelerator_idle_o, cpu_idle_o,
          scratch_reserved_o, boot_busy_o}, 11'h038);
        `CHK({pll_secondary_field_o, pll_output_divider_field_o, pll_input_div_en_o}, 5'h00);
        `CHK({i2c_target_addr_o, scratch_block_o}, {7'h50, 5'h1f});
        `CHK({usb_out_ep_o, uart_odd_parity_o, uart_flow_ctl_o}, (good_src > 3'h3) ? 6'h07 : 6'h00);
        for (i = 0; i < nreq; i = i + 1)
          `CHK(seq[i], exp_src(i));
        `CHK(seq[nreq - 1], good_src);
        $display("Boot done: strap %0d source %0d probes %0d", strap, good_src, nreq);
      end
    end
  endtask
  initial
  begin
    {sys_clk_i, rst_i, clk_sel_strap_i, cfg, load_bad, good_src, fail_mode, delay, entry} = 37'h1_0000_0000 << 2;
    {rnd, cyc, nreq, failures, samples_checked} = {16'h0004, 128'h0};
    boot(1'b0, 3'h0, 2'h0, 1'b0);
    boot(1'b1, 3'h0, 2'h1, 1'b1);
    boot(1'b0, 3'h2, 2'h1, 1'b0);
    boot(1'b1, 3'h3, 2'h2, 1'b0);
    boot(1'b0, 3'h4, 2'h0, 1'b1);
    boot(1'b1, 3'h7, 2'h2, 1'b0);
    for (k = 0; k < 4; k = k + 1)
    begin
      rnd = lfsr(rnd);
      boot(rnd[0], rnd[3:1] % 5, rnd[5:4], rnd[6]);
    end
    complete_run;
  end
endmodule
